// ---- verilog/ufr_pkg.sv ----
package ufr_pkg;

  // Register offsets on the channel's parallel bus
  localparam logic [3:0] UFR_OFS_DIV_LOW = 4'h0;
  localparam logic [3:0] UFR_OFS_DIV_HIGH = 4'h1;
  localparam logic [3:0] UFR_OFS_SCRATCH = 4'h7;
  localparam logic [3:0] UFR_OFS_FEATURE = 4'h8;
  localparam logic [3:0] UFR_OFS_ENHANCED = 4'h9;

  // Values after reset
  localparam logic [7:0] UFR_RST_DIV_LOW = 8'h01;
  localparam logic [7:0] UFR_RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] UFR_RST_SCRATCH = 8'hFF;
  localparam logic [7:0] UFR_RST_FEATURE = 8'h00;
  localparam logic [7:0] UFR_RST_ENHANCED = 8'h00;

  // Feature control field positions
  localparam int UFR_FC_TABLE_HI = 7;
  localparam int UFR_FC_TABLE_LO = 6;
  localparam int UFR_FC_RS485 = 5;
  localparam int UFR_FC_IR_INV = 4;
  localparam int UFR_FC_HYST_HI = 3;

  // Enhanced feature field positions
  localparam int UFR_EF_AUTO_CTS = 7;
  localparam int UFR_EF_AUTO_RTS = 6;
  localparam int UFR_EF_SPECIAL = 5;
  localparam int UFR_EF_ENH_WR = 4;

  // Modem control field positions
  localparam int UFR_MC_PRESCALE = 7;
  localparam int UFR_MC_FLOW_SEL = 2;
  localparam int UFR_MC_RTS = 1;
  localparam int UFR_MC_DTR = 0;

  // Baud generator counts
  localparam logic [2:0] UFR_PRESCALE_FAST = 3'h1;
  localparam logic [2:0] UFR_PRESCALE_SLOW = 3'h4;
  localparam logic [4:0] UFR_OVERSAMPLE_16 = 5'h10;
  localparam logic [4:0] UFR_OVERSAMPLE_8 = 5'h08;

  // Receive fill counter width, enough for 64 plus the largest hysteresis
  localparam int UFR_FILL_W = 7;

  // Flow control output state, one-hot
  typedef enum logic [1:0] {
    UFR_FLOW_ON = 2'b01,
    UFR_FLOW_OFF = 2'b10
  } ufr_flow_e;

endpackage : ufr_pkg

// ---- verilog/ufr_baud_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ufr_baud_if;
  logic [15:0] divisor;
  logic prescale_sel;
  logic mode8x;
  logic sample_tick;
  logic bit_tick;

  modport regs (output divisor, output prescale_sel, output mode8x, input sample_tick, input bit_tick);
  modport gen (input divisor, input prescale_sel, input mode8x, output sample_tick, output bit_tick);
endinterface : ufr_baud_if
`default_nettype wire

// ---- verilog/ufr_baud_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufr_baud_gen (
  input wire logic mclk,   // Input clock
  input wire logic resetn, // Async reset, active low
  ufr_baud_if.gen bif      // Divisor in, ticks out
);
  import ufr_pkg::*;

  logic [2:0] pre_cnt, next_pre_cnt;
  logic [15:0] div_cnt, next_div_cnt;
  logic [4:0] os_cnt, next_os_cnt;
  logic sample_q, next_sample;
  logic bit_q, next_bit;
  logic [2:0] pre_lim;
  logic [4:0] os_lim;

  ////////////////////////////////////////////////////////////////////////////
  // Input clock / (divisor * prescaler) gives the sample tick; 16 or 8 of those a bit
  always_comb begin
    pre_lim = bif.prescale_sel ? UFR_PRESCALE_SLOW : UFR_PRESCALE_FAST;
    os_lim = bif.mode8x ? UFR_OVERSAMPLE_8 : UFR_OVERSAMPLE_16;
    next_pre_cnt = pre_cnt;
    next_div_cnt = div_cnt;
    next_os_cnt = os_cnt;
    next_sample = 1'b0;
    next_bit = 1'b0;
    if (bif.divisor == 16'h0000) begin
      // A zero divisor stops the generator rather than dividing by 65536
      next_pre_cnt = 3'h0;
      next_div_cnt = 16'h0000;
      next_os_cnt = 5'h00;
    end else if (pre_cnt >= pre_lim - 3'h1) begin
      next_pre_cnt = 3'h0;
      if (div_cnt >= bif.divisor - 16'h0001) begin
        next_div_cnt = 16'h0000;
        next_sample = 1'b1;
        if (os_cnt >= os_lim - 5'h01) begin
          next_os_cnt = 5'h00;
          next_bit = 1'b1;
        end else begin
          next_os_cnt = os_cnt + 5'h01;
        end
      end else begin
        next_div_cnt = div_cnt + 16'h0001;
      end
    end else begin
      next_pre_cnt = pre_cnt + 3'h1;
    end
  end

  // Counter and tick registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt <= 3'h0;
      div_cnt <= 16'h0000;
      os_cnt <= 5'h00;
      sample_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      os_cnt <= next_os_cnt;
      sample_q <= next_sample;
      bit_q <= next_bit;
    end
  end

  assign bif.sample_tick = sample_q;
  assign bif.bit_tick = bit_q;

  ////////////////////////////////////////////////////////////////////////////
  chk_bit_on_sample: assert property (@(posedge mclk) disable iff (!resetn)
    bif.bit_tick |-> bif.sample_tick)
    else $error("bit tick without sample tick");

  chk_zero_div_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    (bif.divisor == 16'h0000)[*2] |-> !bif.sample_tick)
    else $error("sample tick with zero divisor");

  chk_unit_div_rate: assert property (@(posedge mclk) disable iff (!resetn)
    (bif.divisor == 16'h0001 && !bif.prescale_sel)[*3] |-> bif.sample_tick)
    else $error("divisor one fast prescale must tick every clock");

endmodule : ufr_baud_gen
`default_nettype wire

// ---- verilog/ufr_feature_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Scratch byte, resets to all ones, kept in sleep
// - Divisor low byte reachable only with divisor access
// - Divisor high byte, resets zero, divisor access only
// - Baud = clock / (divisor * prescaler * 16 or 8)
// - Feature bits 7:6 pick trigger table A-D
// - Feature bit 5 lets transmitter drive RTS
// - Feature bits 3:0 pick hysteresis, low codes
// - Hysteresis codes with bit 3 set
// - Enhanced bit 7 gates transmit by CTS/DSR
// - Enhanced bit 6 drives RTS/DTR from fill
// - Special character match enters FIFO, flags event
// - Xoff2 compare withholds char, raises both events
// - Enhanced bit 4 opens enhanced writes, sleep
module ufr_feature_regs
#(
  parameter int FILL_W = ufr_pkg::UFR_FILL_W // Receive fill counter width
) (
  input wire logic mclk,                         // Input clock, 25 MHz
  input wire logic resetn,                       // Async reset, active low
  input wire logic [3:0] bus_addr,               // Register offset
  input wire logic [7:0] bus_wdata,              // Write data
  input wire logic bus_wr,                       // Write strobe, one cycle
  input wire logic bus_rd,                       // Read strobe, one cycle
  output logic [7:0] bus_rdata,                  // Read data, registered
  output logic bus_hit,                          // Address belongs to this block
  input wire logic line_control_dlab,            // Divisor access bit
  input wire logic [7:0] modem_control,          // Modem control register
  input wire logic eight_times_oversample_sel,   // 8x oversampling select
  output logic baud_sample_tick,                 // Oversample tick pulse
  output logic baud_bit_tick,                    // Bit time tick pulse
  output logic [1:0] trigger_table,              // Trigger level table select
  output logic enhanced_write_en,                // Enhanced bits writable
  output logic sleep_permit,                     // Sleep mode allowed
  input wire logic [FILL_W-1:0] rx_fifo_fill,    // Receive FIFO fill
  input wire logic [FILL_W-1:0] rx_trigger_level, // Receive trigger level
  input wire logic tx_busy,                      // Transmitter holds data
  input wire logic cts_pin_n,                    // Clear-to-send pin, active low
  input wire logic dsr_pin_n,                    // Data-set-ready pin, active low
  output logic rts_assert,                       // Request-to-send asserted
  output logic dtr_assert,                       // Terminal-ready asserted
  output logic tx_permit,                        // Transmitter may start
  input wire logic ir_rx_pin,                    // Infrared receive pin
  output logic ir_rx_data,                       // Infrared data, active high
  input wire logic rx_char_valid,                // Received character strobe
  input wire logic [7:0] rx_char,                // Received character
  input wire logic [7:0] xoff2_value,            // Second Xoff character
  input wire logic swfc_xoff2_compare,           // Software flow compares Xoff2
  output logic fifo_push,                        // Push into receive FIFO, pulse
  output logic [7:0] fifo_data,                  // Character to push
  output logic special_char_event,               // Special character pulse
  output logic xoff_event                        // Xoff received pulse
);
  import ufr_pkg::*;

  if (FILL_W < 7) begin : g_fill_check
    $error("FILL_W must be at least 7");
  end

  localparam int SEL_W = 5;

  // One-hot register select; divisor bytes hide behind the divisor access bit
  function automatic logic [SEL_W-1:0] ufr_decode(input logic [3:0] addr, input logic dlab);
    logic [SEL_W-1:0] sel;
    sel = '0;
    sel[0] = dlab && (addr == UFR_OFS_DIV_LOW);
    sel[1] = dlab && (addr == UFR_OFS_DIV_HIGH);
    sel[2] = (addr == UFR_OFS_SCRATCH);
    sel[3] = (addr == UFR_OFS_FEATURE);
    sel[4] = (addr == UFR_OFS_ENHANCED);
    return sel;
  endfunction : ufr_decode

  // Hysteresis code to characters
  function automatic logic [FILL_W-1:0] ufr_hyst(input logic [3:0] code);
    logic [5:0] h;
    h = 6'h00;
    case (code)
      4'h0: h = 6'h00;
      4'h1: h = 6'h04;
      4'h2: h = 6'h06;
      4'h3: h = 6'h08;
      4'h4: h = 6'h08;
      4'h5: h = 6'h10;
      4'h6: h = 6'h18;
      4'h7: h = 6'h20;
      4'h8: h = 6'h28;
      4'h9: h = 6'h2C;
      4'hA: h = 6'h30;
      4'hB: h = 6'h34;
      4'hC: h = 6'h0C;
      4'hD: h = 6'h14;
      4'hE: h = 6'h1C;
      4'hF: h = 6'h24;
      default: h = 6'h00;
    endcase
    return FILL_W'(h);
  endfunction : ufr_hyst

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] div_low, next_div_low;
  logic [7:0] div_high, next_div_high;
  logic [7:0] scratch_byte, next_scratch_byte;
  logic [7:0] feature_control, next_feature_control;
  logic [7:0] enhanced_feature, next_enhanced_feature;
  logic [7:0] rdata_q, next_rdata;
  logic [SEL_W-1:0] sel;

  // Scratch is never touched by sleep, so its value survives it
  always_comb begin
    sel = ufr_decode(bus_addr, line_control_dlab);
    next_div_low = div_low;
    next_div_high = div_high;
    next_scratch_byte = scratch_byte;
    next_feature_control = feature_control;
    next_enhanced_feature = enhanced_feature;
    next_rdata = rdata_q;
    if (bus_wr) begin
      if (sel[0]) next_div_low = bus_wdata;
      if (sel[1]) next_div_high = bus_wdata;
      if (sel[2]) next_scratch_byte = bus_wdata;
      if (sel[3]) next_feature_control = bus_wdata;
      if (sel[4]) next_enhanced_feature = bus_wdata;
    end
    if (bus_rd) begin
      // Unselected offsets read zero; they belong to the neighbouring registers
      next_rdata = ({8{sel[0]}} & div_low) | ({8{sel[1]}} & div_high) |
                   ({8{sel[2]}} & scratch_byte) | ({8{sel[3]}} & feature_control) |
                   ({8{sel[4]}} & enhanced_feature);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_low <= UFR_RST_DIV_LOW;
      div_high <= UFR_RST_DIV_HIGH;
      scratch_byte <= UFR_RST_SCRATCH;
      feature_control <= UFR_RST_FEATURE;
      enhanced_feature <= UFR_RST_ENHANCED;
      rdata_q <= 8'h00;
    end else begin
      div_low <= next_div_low;
      div_high <= next_div_high;
      scratch_byte <= next_scratch_byte;
      feature_control <= next_feature_control;
      enhanced_feature <= next_enhanced_feature;
      rdata_q <= next_rdata;
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_hit = |sel;
  assign trigger_table = feature_control[UFR_FC_TABLE_HI:UFR_FC_TABLE_LO];
  assign enhanced_write_en = enhanced_feature[UFR_EF_ENH_WR];
  assign sleep_permit = enhanced_feature[UFR_EF_ENH_WR];

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator
  ufr_baud_if bif ();

  assign bif.divisor = {div_high, div_low};
  assign bif.prescale_sel = modem_control[UFR_MC_PRESCALE];
  assign bif.mode8x = eight_times_oversample_sel;

  ufr_baud_gen u_baud (
    .mclk(mclk),
    .resetn(resetn),
    .bif(bif)
  );

  assign baud_sample_tick = bif.sample_tick;
  assign baud_bit_tick = bif.bit_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: CTS, DSR, infrared receive
  logic [2:0] pin_meta, pin_sync;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 3'b011;
      pin_sync <= 3'b011;
    end else begin
      pin_meta <= {ir_rx_pin, dsr_pin_n, cts_pin_n};
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive fill hysteresis; below-band reassert falls back to empty when band reaches zero
  ufr_flow_e flow_state, next_flow_state;
  logic [FILL_W-1:0] hyst;
  logic [FILL_W:0] hi_mark;
  logic reassert_ok;

  always_comb begin
    hyst = ufr_hyst(feature_control[UFR_FC_HYST_HI:0]);
    hi_mark = {1'b0, rx_trigger_level} + {1'b0, hyst};
    if (rx_trigger_level > hyst) begin
      reassert_ok = ({1'b0, rx_fifo_fill} + {1'b0, hyst}) < {1'b0, rx_trigger_level};
    end else begin
      reassert_ok = (rx_fifo_fill == '0);
    end
    next_flow_state = flow_state;
    case (flow_state)
      UFR_FLOW_ON: begin
        if ({1'b0, rx_fifo_fill} > hi_mark) next_flow_state = UFR_FLOW_OFF;
      end
      UFR_FLOW_OFF: begin
        if (reassert_ok) next_flow_state = UFR_FLOW_ON;
      end
      default: next_flow_state = UFR_FLOW_ON;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flow_state <= UFR_FLOW_ON;
    end else begin
      flow_state <= next_flow_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem outputs, transmit gating and infrared polarity
  logic next_rts, next_dtr, next_tx_permit, next_ir;
  logic rts_q, dtr_q, tx_permit_q, ir_q;
  logic flow_ok, gate_in;

  // RS-485 direction wins over automatic flow, which wins over the manual bits
  always_comb begin
    flow_ok = (flow_state == UFR_FLOW_ON);
    next_rts = modem_control[UFR_MC_RTS];
    next_dtr = modem_control[UFR_MC_DTR];
    if (enhanced_feature[UFR_EF_AUTO_RTS]) begin
      if (modem_control[UFR_MC_FLOW_SEL]) next_dtr = flow_ok;
      else next_rts = flow_ok;
    end
    if (feature_control[UFR_FC_RS485]) next_rts = tx_busy;
    gate_in = modem_control[UFR_MC_FLOW_SEL] ? !pin_sync[1] : !pin_sync[0];
    next_tx_permit = !enhanced_feature[UFR_EF_AUTO_CTS] || gate_in;
    next_ir = pin_sync[2] ^ feature_control[UFR_FC_IR_INV];
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rts_q <= 1'b0;
      dtr_q <= 1'b0;
      tx_permit_q <= 1'b1;
      ir_q <= 1'b0;
    end else begin
      rts_q <= next_rts;
      dtr_q <= next_dtr;
      tx_permit_q <= next_tx_permit;
      ir_q <= next_ir;
    end
  end

  assign rts_assert = rts_q;
  assign dtr_assert = dtr_q;
  assign tx_permit = tx_permit_q;
  assign ir_rx_data = ir_q;

  ////////////////////////////////////////////////////////////////////////////
  // Special character detection on the received stream
  logic next_push, next_special, next_xoff;
  logic [7:0] next_fifo_data;
  logic push_q, special_q, xoff_q;
  logic [7:0] fifo_data_q;
  logic match;

  always_comb begin
    match = enhanced_feature[UFR_EF_SPECIAL] && (rx_char == xoff2_value);
    next_push = rx_char_valid;
    next_special = rx_char_valid && match;
    next_xoff = 1'b0;
    next_fifo_data = rx_char_valid ? rx_char : fifo_data_q;
    if (rx_char_valid && match && swfc_xoff2_compare) begin
      next_push = 1'b0;
      next_xoff = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      push_q <= 1'b0;
      special_q <= 1'b0;
      xoff_q <= 1'b0;
      fifo_data_q <= 8'h00;
    end else begin
      push_q <= next_push;
      special_q <= next_special;
      xoff_q <= next_xoff;
      fifo_data_q <= next_fifo_data;
    end
  end

  assign fifo_push = push_q;
  assign special_char_event = special_q;
  assign xoff_event = xoff_q;
  assign fifo_data = fifo_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write, one idle cycle, then read back: the usual spacing of a host
  chk_scratch_write: assert property (@(posedge mclk) disable iff (!resetn)
    bus_wr && bus_addr == UFR_OFS_SCRATCH ##1 !bus_wr ##1 bus_rd && bus_addr == UFR_OFS_SCRATCH && !bus_wr
    |=> bus_rdata == $past(bus_wdata, 3))
    else $error("scratch byte did not keep written value");
  chk_div_low_gate: assert property (@(posedge mclk) disable iff (!resetn)
    bus_wr && bus_addr == UFR_OFS_DIV_LOW && !line_control_dlab |=> $stable(div_low))
    else $error("divisor low written without divisor access");
  chk_div_high_gate: assert property (@(posedge mclk) disable iff (!resetn)
    bus_wr && bus_addr == UFR_OFS_DIV_HIGH && !line_control_dlab |=> $stable(div_high))
    else $error("divisor high written without divisor access");
  chk_rs485_rts: assert property (@(posedge mclk) disable iff (!resetn)
    feature_control[UFR_FC_RS485] && tx_busy |=> rts_assert)
    else $error("transmitter did not drive RTS in RS-485 mode");
  chk_ir_polarity: assert property (@(posedge mclk) disable iff (!resetn)
    $stable(feature_control) |-> ir_rx_data == $past(pin_sync[2] ^ feature_control[UFR_FC_IR_INV]))
    else $error("infrared polarity wrong");
  chk_flow_off: assert property (@(posedge mclk) disable iff (!resetn)
    flow_state == UFR_FLOW_ON && {1'b0, rx_fifo_fill} > hi_mark |=> flow_state == UFR_FLOW_OFF)
    else $error("flow not withdrawn above band");
  chk_tx_gate: assert property (@(posedge mclk) disable iff (!resetn)
    enhanced_feature[UFR_EF_AUTO_CTS] && !gate_in |=> !tx_permit)
    else $error("transmit not gated by modem input");
  chk_special_push: assert property (@(posedge mclk) disable iff (!resetn)
    rx_char_valid && match && !swfc_xoff2_compare |=> fifo_push && special_char_event && !xoff_event)
    else $error("special character not pushed and flagged");
  chk_xoff2_held: assert property (@(posedge mclk) disable iff (!resetn)
    rx_char_valid && match && swfc_xoff2_compare |=> !fifo_push && xoff_event && special_char_event)
    else $error("compared Xoff2 not withheld");
endmodule : ufr_feature_regs
`default_nettype wire

// ---- verification/ufr_line_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module ufr_line_partner (
  input wire logic mclk,        // Line clock
  input wire logic resetn,      // Reset, active low
  input wire logic rts_assert,  // Our request line
  input wire logic dtr_assert,  // Our ready line
  input wire logic [3:0] lag,   // Answer delay in cycles, less one
  output logic cts_pin_n,       // Answer to request, active low
  output logic dsr_pin_n        // Answer to ready, active low
);
  logic [15:0] rh;
  logic [15:0] dh;
  // Remote end echoes our lines late; a slow answer stresses the gating
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rh <= '0;
      dh <= '0;
    end else begin
      rh <= {rh[14:0], rts_assert};
      dh <= {dh[14:0], dtr_assert};
    end
  end
  // Deasserted while in reset, like a pulled-up idle pin
  assign cts_pin_n = !rh[lag];
  assign dsr_pin_n = !dh[lag];
endmodule : ufr_line_partner
`default_nettype wire

// ---- verification/uart_channel_feature_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module uart_channel_feature_regs_bench;
  import ufr_pkg::*;
  logic mclk, resetn, bus_wr, bus_rd, dlab, x8, tx_busy, ir_pin, rx_v, cmp, rd_f;
  logic hit, stick, btick, ewe, slp, rts, dtr, txp, ir_d, push, spec, xoff, cts_n, dsr_n;
  logic [3:0] addr, lag;
  logic [7:0] wdata, mc, rxc, xoff2, rdata, fdata, d;
  logic [6:0] fill, trig;
  logic [1:0] ttab;
  logic [7:0] rq[$];
  logic [10:0] pq[$];
  int hy[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
  int error_cnt, n_checks, cyc, seed;

  ufr_feature_regs DUT (.mclk(mclk), .resetn(resetn), .bus_addr(addr), .bus_wdata(wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(rdata), .bus_hit(hit), .line_control_dlab(dlab), .modem_control(mc),
    .eight_times_oversample_sel(x8), .baud_sample_tick(stick), .baud_bit_tick(btick), .trigger_table(ttab),
    .enhanced_write_en(ewe), .sleep_permit(slp), .rx_fifo_fill(fill), .rx_trigger_level(trig),
    .tx_busy(tx_busy), .cts_pin_n(cts_n), .dsr_pin_n(dsr_n), .rts_assert(rts), .dtr_assert(dtr),
    .tx_permit(txp), .ir_rx_pin(ir_pin), .ir_rx_data(ir_d), .rx_char_valid(rx_v), .rx_char(rxc),
    .xoff2_value(xoff2), .swfc_xoff2_compare(cmp), .fifo_push(push), .fifo_data(fdata),
    .special_char_event(spec), .xoff_event(xoff));
  ufr_line_partner peer (.mclk(mclk), .resetn(resetn), .rts_assert(rts), .dtr_assert(dtr), .lag(lag),
    .cts_pin_n(cts_n), .dsr_pin_n(dsr_n));

  ////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude;
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge mclk);
    addr = a;
    wdata = v;
    bus_wr = 1'b1;
    @(negedge mclk);
    bus_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge mclk);
    addr = a;
    bus_rd = 1'b1;
    rq.push_back(e);
    @(negedge mclk);
    bus_rd = 1'b0;
  endtask : rd
  task automatic snd(input logic [7:0] c, input logic [10:0] e);
    @(negedge mclk);
    rxc = c;
    rx_v = 1'b1;
    pq.push_back(e);
    @(negedge mclk);
    rx_v = 1'b0;
  endtask : snd
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask : settle
  // Third gap between ticks, so a divisor change has fully taken hold
  task automatic gap(input logic bt, input int e);
    int k;
    k = 0;
    repeat (3) begin
      k = 0;
      @(negedge mclk);
      while ((bt ? btick : stick) !== 1'b1 && k < 5000) begin
        k++;
        @(negedge mclk);
      end
    end
    check(bt ? "bit gap" : "sample gap", 16'(k + 1), 16'(e));
  endtask : gap
  task automatic baud(input logic [7:0] lo, hi, m, input logic x, input int s);
    wr(UFR_OFS_DIV_LOW, lo);
    wr(UFR_OFS_DIV_HIGH, hi);
    mc = m;
    x8 = x;
    gap(1'b0, s);
    gap(1'b1, s * (x ? 8 : 16));
  endtask : baud

  ////////////////////////////////////////////////////////////
  // Clock and cycle ceiling
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    rd_f <= bus_rd;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end
  // Results settle by the falling edge; the oldest note is compared
  always @(negedge mclk) begin
    if (rd_f)
      check("read data", {8'h00, rdata}, {8'h00, rq.pop_front()});
    if (push || spec || xoff)
      check("char event", {5'h00, push, spec, xoff, push ? fdata : 8'h00}, {5'h00, pq.pop_front()});
  end
  // Main sequence
  initial begin
    {resetn, bus_wr, bus_rd, dlab, x8, tx_busy, ir_pin, rx_v, cmp} = '0;
    {addr, wdata, rxc, mc} = '0;
    xoff2 = 8'h13;
    fill = '0;
    trig = 7'd60;
    lag = 4'h4;
    seed = 32'h2139;
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    dlab = 1'b1;
    rd(UFR_OFS_DIV_LOW, 8'h01);
    rd(UFR_OFS_DIV_HIGH, 8'h00);
    rd(UFR_OFS_SCRATCH, 8'hFF);
    rd(UFR_OFS_FEATURE, 8'h00);
    rd(UFR_OFS_ENHANCED, 8'h00);
    check("tx permit", {15'h0, txp}, 16'h0001);
    dlab = 1'b0;
    wr(UFR_OFS_DIV_LOW, 8'h55);
    wr(UFR_OFS_DIV_HIGH, 8'hAA);
    rd(UFR_OFS_DIV_LOW, 8'h00);
    check("hit", {15'h0, hit}, 16'h0000);
    rd(4'hC, 8'h00);
    dlab = 1'b1;
    rd(UFR_OFS_DIV_LOW, 8'h01);
    rd(UFR_OFS_DIV_HIGH, 8'h00);
    d = 8'($random(seed));
    wr(UFR_OFS_SCRATCH, d);
    rd(UFR_OFS_SCRATCH, d);
    wr(UFR_OFS_DIV_HIGH, ~d);
    rd(UFR_OFS_DIV_HIGH, ~d);
    wr(UFR_OFS_FEATURE, d);
    settle(1);
    check("table", {14'h0, ttab}, {14'h0, d[7:6]});
    d = 8'($random(seed)) | 8'h10;
    wr(UFR_OFS_ENHANCED, d);
    rd(UFR_OFS_ENHANCED, d);
    check("enh write", {14'h0, ewe, slp}, 16'h0003);
    baud(8'h03, 8'h00, 8'h00, 1'b0, 3);
    baud(8'h03, 8'h00, 8'h80, 1'b1, 12);
    baud(8'h02, 8'h01, 8'h00, 1'b1, 258);
    // A zero divisor must stop the sample ticks altogether
    wr(UFR_OFS_DIV_HIGH, 8'h00);
    wr(UFR_OFS_DIV_LOW, 8'h00);
    repeat (20) begin
      @(negedge mclk);
      check("stopped", {15'h0, stick}, 16'h0000);
    end
    wr(UFR_OFS_ENHANCED, 8'h00);
    mc = 8'h00;
    wr(UFR_OFS_FEATURE, 8'h10);
    settle(4);
    check("ir inverted", {15'h0, ir_d}, 16'h0001);
    ir_pin = 1'b1;
    settle(4);
    check("ir inverted high", {15'h0, ir_d}, 16'h0000);
    wr(UFR_OFS_FEATURE, 8'h20);
    tx_busy = 1'b1;
    settle(2);
    check("rs485 on", {15'h0, rts}, 16'h0001);
    tx_busy = 1'b0;
    settle(2);
    check("rs485 off", {15'h0, rts}, 16'h0000);
    check("ir normal", {15'h0, ir_d}, 16'h0001);
    wr(UFR_OFS_ENHANCED, 8'h40);
    for (int c = 0; c < 16; c++) begin
      wr(UFR_OFS_FEATURE, 8'(c));
      fill = 7'(60 + hy[c]);
      settle(3);
      check("hold on", {15'h0, rts}, 16'h0001);
      fill = 7'(61 + hy[c]);
      settle(3);
      check("flow off", {15'h0, rts}, 16'h0000);
      fill = 7'(60 - hy[c]);
      settle(3);
      check("hold off", {15'h0, rts}, 16'h0000);
      fill = 7'(59 - hy[c]);
      settle(3);
      check("flow on", {15'h0, rts}, 16'h0001);
    end
    wr(UFR_OFS_ENHANCED, 8'hC0);
    fill = 7'd120;
    settle(12);
    check("cts gate", {15'h0, txp}, 16'h0000);
    fill = 7'd0;
    settle(12);
    check("cts open", {15'h0, txp}, 16'h0001);
    lag = 4'h0;
    mc = 8'h04;
    settle(3);
    check("dtr on", {15'h0, dtr}, 16'h0001);
    fill = 7'd120;
    settle(8);
    check("dsr gate", {14'h0, dtr, txp}, 16'h0000);
    wr(UFR_OFS_ENHANCED, 8'h20);
    snd(8'h13, {3'b110, 8'h13});
    snd(8'h41, {3'b100, 8'h41});
    cmp = 1'b1;
    snd(8'h13, {3'b011, 8'h00});
    cmp = 1'b0;
    wr(UFR_OFS_ENHANCED, 8'h00);
    snd(8'h13, {3'b100, 8'h13});
    settle(3);
    check("notes left", 16'(pq.size() + rq.size()), 16'h0000);
    conclude();
  end
endmodule : uart_channel_feature_regs_bench
`default_nettype wire
